//--- src/svxe_defs.svh
// constants for the stop, vector-entry and exchange execution block
// assumes one cpu clock; included by bare name by the design file
`ifndef SVXE_DEFS_SVH
`define SVXE_DEFS_SVH
`define SVXE_OP_STOP1     8'hFF
`define SVXE_OP_STOP2     8'hB3
`define SVXE_OP_XDA       8'h79
`define SVXE_OP_XEDA      8'hCF
`define SVXE_OP_PFX       8'hDC
`define SVXE_OP_HL2       8'h01
`define SVXE_RA_HI        5'h0D
`define SVXE_RRA_HI       5'h0F
`define SVXE_RRB_HI       5'h1C
`define SVXE_POWER_CONTROL_REG_STOP    3
`define SVXE_VEC_BASE     14'h0000
`define SVXE_HL_IDX       2'h3
`endif

//--- src/svxe_pkg.sv
// types for the stop, vector-entry and exchange execution block
// assumes the defs header sits on the include path
package svxe_pkg;
  typedef enum logic [3:0] {
    SVXE_FETCH,
    SVXE_STOP2,
    SVXE_HALT,
    SVXE_VEC1,
    SVXE_XDA,
    SVXE_XEDA,
    SVXE_PFX,
    SVXE_EHI,
    SVXE_IRQ,
    SVXE_RET
  } svxe_state_t;
endpackage

//--- src/svxe_exec.sv
// execution of stop, vector entry and the exchange instructions
// assumes rom answers the cycle after o_rom_addr, ram write is a single-cycle strobe,
// ram read data is valid combinationally for the present o_ram_addr
`include "svxe_defs.svh"
`timescale 1ns/100ps
module svxe_exec (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_rom_data,
  input  wire logic [3:0]  i_ram_rdata,
  input  wire logic        i_wake,
  input  wire logic        i_irq,
  input  wire logic [2:0]  i_irq_num,
  input  wire logic        i_interrupt_return_op,
  input  wire logic [1:0]  i_reg_bank_sel,
  input  wire logic [3:0]  i_mem_bank,
  output logic      [13:0] o_rom_addr,
  output logic      [11:0] o_ram_addr,
  output logic      [3:0]  o_ram_wdata,
  output logic             o_ram_we,
  output logic      [13:0] o_pc,
  output logic      [7:0]  o_ext_acc,
  output logic             o_mem_bank_en,
  output logic             o_reg_bank_en,
  output logic      [3:0]  o_power_control_reg,
  output logic             o_clock_stopped
);
  svxe_pkg::svxe_state_t st_r;
  logic [7:0]  wr_r [0:7];   // working registers of the active bank (mirror)
  logic [7:0]  addr_r;
  logic [1:0]  saved_flags_r;
  logic [2:0]  vec_r;
  logic [13:0] pc_r;
  logic [1:0]  bank_w;
  logic [7:0]  op_w;
  logic        pend_lo_r;    // low nibble loads from ram at the next edge
  logic        pend_hi_r;    // high nibble loads from ram at the next edge
  logic [7:0]  acc_w;        // accumulator with a pending ram load forwarded

  // ram read data belongs to the registered o_ram_addr, so a swap first
  // points the ram at its location together with the write strobe; at the
  // following edge the old nibble is taken while the ram stores the new one.
  // a later instruction that reads the accumulator in that same cycle sees
  // the forwarded value, so back-to-back exchanges stay correct
  assign acc_w = {pend_hi_r ? i_ram_rdata : o_ext_acc[7:4],
                  pend_lo_r ? i_ram_rdata : o_ext_acc[3:0]};

  // bank zero forced when register-bank enable is clear
  assign bank_w = o_reg_bank_en ? i_reg_bank_sel : 2'h0;
  assign op_w   = i_rom_data;

  // working register location in data memory, bank times eight
  function automatic logic [11:0] svxe_wreg(input logic [1:0] b, input logic [2:0] r);
    svxe_wreg = {7'h00, b, r};
  endfunction

  function automatic logic [11:0] svxe_dmem(input logic [3:0] mb, input logic [7:0] a);
    svxe_dmem = {mb, a};
  endfunction

  // main sequencer; the bank-enable flags change only on vector entry and interrupt return
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_r                <= svxe_pkg::SVXE_VEC1;
      vec_r               <= 3'h0;
      o_rom_addr          <= `SVXE_VEC_BASE;
      pc_r                <= 14'h0000;
      o_pc                <= 14'h0000;
      o_ext_acc           <= 8'h00;
      o_mem_bank_en       <= 1'b0;
      o_reg_bank_en       <= 1'b0;
      o_power_control_reg <= 4'h0;
      o_clock_stopped     <= 1'b0;
      o_ram_addr          <= 12'h000;
      o_ram_wdata         <= 4'h0;
      o_ram_we            <= 1'b0;
      addr_r              <= 8'h00;
      saved_flags_r       <= 2'h0;
      pend_lo_r           <= 1'b0;
      pend_hi_r           <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        wr_r[i] <= 8'h00;
      end
    end else begin
      o_ram_we  <= 1'b0;
      pend_lo_r <= 1'b0;
      pend_hi_r <= 1'b0;
      // finish the read half of the previous swap
      if (pend_lo_r) begin
        o_ext_acc[3:0] <= i_ram_rdata;
      end
      if (pend_hi_r) begin
        o_ext_acc[7:4] <= i_ram_rdata;
      end
      case (st_r)
        svxe_pkg::SVXE_FETCH: begin
          o_rom_addr <= o_rom_addr + 14'h0001;
          if (i_irq) begin
            // push flags, then jump through the table
            saved_flags_r <= {o_mem_bank_en, o_reg_bank_en};
            vec_r         <= i_irq_num;
            o_rom_addr    <= `SVXE_VEC_BASE + {10'h000, i_irq_num, 1'b0};
            st_r          <= svxe_pkg::SVXE_VEC1;
          end else if (i_interrupt_return_op) begin
            {o_mem_bank_en, o_reg_bank_en} <= saved_flags_r;
          end else if (op_w == `SVXE_OP_STOP1) begin
            st_r <= svxe_pkg::SVXE_STOP2;
          end else if (op_w == `SVXE_OP_XDA) begin
            st_r <= svxe_pkg::SVXE_XDA;
          end else if (op_w == `SVXE_OP_XEDA) begin
            st_r <= svxe_pkg::SVXE_XEDA;
          end else if (op_w == `SVXE_OP_PFX) begin
            st_r <= svxe_pkg::SVXE_PFX;
          end else if (op_w[7:3] == `SVXE_RA_HI) begin
            // one-cycle swap of the low nibble with the working register
            o_ext_acc[3:0] <= wr_r[op_w[2:0]][3:0];
            wr_r[op_w[2:0]][3:0] <= acc_w[3:0];
            o_ram_addr  <= svxe_wreg(bank_w, op_w[2:0]);
            o_ram_wdata <= acc_w[3:0];
            o_ram_we    <= 1'b1;
          end else if (op_w[7:3] == `SVXE_RRA_HI) begin
            // even register of the pointer pair holds the address; ram data is taken at the next edge
            pend_lo_r   <= 1'b1;
            o_ram_addr  <= svxe_dmem(i_mem_bank, wr_r[op_w[2:0] & 3'h6]);
            o_ram_wdata <= acc_w[3:0];
            o_ram_we    <= 1'b1;
          end
        end
        svxe_pkg::SVXE_STOP2: begin
          if (op_w == `SVXE_OP_STOP2) begin
            o_power_control_reg[`SVXE_POWER_CONTROL_REG_STOP] <= 1'b1;
            o_clock_stopped <= 1'b1;
            st_r <= svxe_pkg::SVXE_HALT;
          end else begin
            st_r <= svxe_pkg::SVXE_FETCH;
          end
          o_rom_addr <= o_rom_addr + 14'h0001;
        end
        svxe_pkg::SVXE_HALT: begin
          // nothing advances; the no-op padding is software's job
          if (i_wake) begin
            o_power_control_reg[`SVXE_POWER_CONTROL_REG_STOP] <= 1'b0;
            o_clock_stopped <= 1'b0;
            st_r <= svxe_pkg::SVXE_FETCH;
          end
        end
        svxe_pkg::SVXE_VEC1: begin
          {o_mem_bank_en, o_reg_bank_en} <= op_w[7:6];
          pc_r[13:8] <= op_w[5:0];
          o_rom_addr <= o_rom_addr + 14'h0001;
          st_r       <= svxe_pkg::SVXE_RET;
        end
        svxe_pkg::SVXE_RET: begin
          // target stays in the 14-bit rom space by width
          o_pc       <= {pc_r[13:8], op_w};
          o_rom_addr <= {pc_r[13:8], op_w};
          st_r       <= svxe_pkg::SVXE_FETCH;
        end
        svxe_pkg::SVXE_XDA: begin
          pend_lo_r      <= 1'b1;
          o_ram_wdata    <= acc_w[3:0];
          o_ram_addr     <= svxe_dmem(i_mem_bank, op_w);
          o_ram_we       <= 1'b1;
          o_rom_addr     <= o_rom_addr + 14'h0001;
          st_r           <= svxe_pkg::SVXE_FETCH;
        end
        svxe_pkg::SVXE_XEDA: begin
          addr_r         <= op_w;
          pend_lo_r      <= 1'b1;
          o_ram_wdata    <= acc_w[3:0];
          o_ram_addr     <= svxe_dmem(i_mem_bank, op_w);
          o_ram_we       <= 1'b1;
          st_r           <= svxe_pkg::SVXE_EHI;
        end
        svxe_pkg::SVXE_PFX: begin
          if (op_w == `SVXE_OP_HL2) begin
            addr_r         <= wr_r[{`SVXE_HL_IDX, 1'b0}];
            pend_lo_r      <= 1'b1;
            o_ram_wdata    <= acc_w[3:0];
            o_ram_addr     <= svxe_dmem(i_mem_bank, wr_r[{`SVXE_HL_IDX, 1'b0}]);
            o_ram_we       <= 1'b1;
            st_r           <= svxe_pkg::SVXE_EHI;
          end else begin
            if (op_w[7:3] == `SVXE_RRB_HI) begin
              o_ext_acc <= wr_r[{op_w[2:1], 1'b0}];
              wr_r[{op_w[2:1], 1'b0}] <= acc_w;
            end
            o_rom_addr <= o_rom_addr + 14'h0001;
            st_r       <= svxe_pkg::SVXE_FETCH;
          end
        end
        svxe_pkg::SVXE_EHI: begin
          // second nibble at address plus one
          pend_hi_r      <= 1'b1;
          o_ram_wdata    <= acc_w[7:4];
          o_ram_addr     <= svxe_dmem(i_mem_bank, addr_r + 8'h01);
          o_ram_we       <= 1'b1;
          o_rom_addr     <= o_rom_addr + 14'h0001;
          st_r           <= svxe_pkg::SVXE_FETCH;
        end
        default: st_r <= svxe_pkg::SVXE_FETCH;
      endcase
    end
  end
endmodule

//--- tb/svxe_exec_checker.sv
// assertions on the ports of the stop, vector-entry and exchange block
// assumes one cpu clock and a synchronous active-low reset; bound below
`timescale 1ns/100ps
module svxe_exec_checker (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic [7:0]  i_rom_data,
  input wire logic        i_wake,
  input wire logic [13:0] o_rom_addr,
  input wire logic        o_ram_we,
  input wire logic [13:0] o_pc,
  input wire logic [7:0]  o_ext_acc,
  input wire logic        o_mem_bank_en,
  input wire logic        o_reg_bank_en,
  input wire logic [3:0]  o_power_control_reg,
  input wire logic        o_clock_stopped
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // stop mode only ever with the stop bit up
  chk_stop_bit_up: assert property (o_clock_stopped |-> o_power_control_reg[3])
    else $error("stopped without stop bit");
  // bit rises only on ff then b3
  chk_stop_two_byte: assert property ($rose(o_power_control_reg[3]) |->
    $past(i_rom_data) == 8'hB3 && $past(i_rom_data, 2) == 8'hFF) else $error("stop decode");
  // a halted core neither fetches, writes nor changes its accumulator
  chk_halt_no_fetch: assert property (o_clock_stopped && $past(o_clock_stopped)
    |-> $stable(o_rom_addr) && $stable(o_ext_acc)) else $error("activity in stop");
  chk_halt_no_write: assert property (o_clock_stopped |-> !o_ram_we)
    else $error("ram write in stop");
  chk_wake_leaves: assert property (o_clock_stopped && i_wake |-> ##[1:4] !o_clock_stopped)
    else $error("no exit from stop");
  // vector load: flags and pc13-8 from the even byte, pc7-0 from the odd one
  chk_vector_load: assert property ($changed(o_pc) |-> o_pc[7:0] == $past(i_rom_data)
    && o_pc[13:8] == $past(i_rom_data[5:0], 2) && o_mem_bank_en == $past(i_rom_data[7], 2)
    && o_reg_bank_en == $past(i_rom_data[6], 2)) else $error("vector fields");
  // fetch starts at the table base with cleared state
  chk_reset_base: assert property ($rose(i_nrst) |-> o_rom_addr == 14'h0000
    && o_pc == 14'h0000 && o_power_control_reg == 4'h0) else $error("reset state");
  // exchanges touch no flags and no program counter
  chk_xch_flags: assert property (o_ram_we |-> $stable(o_mem_bank_en)
    && $stable(o_reg_bank_en) && $stable(o_pc)) else $error("flags moved on exchange");
endmodule
bind svxe_exec svxe_exec_checker u_chk (.i_clock, .i_nrst, .i_rom_data, .i_wake, .o_rom_addr,
  .o_ram_we, .o_pc, .o_ext_acc, .o_mem_bank_en, .o_reg_bank_en, .o_power_control_reg,
  .o_clock_stopped);

//--- tb/svxe_mem_model.sv
// program rom and data ram standing beside the execution block
// assumes the bench loads rom_r and ram_r before reset is released
`timescale 1ns/100ps
module svxe_mem_model (
  input  wire logic        i_clock,
  input  wire logic [13:0] i_rom_addr,
  input  wire logic [11:0] i_ram_addr,
  input  wire logic [3:0]  i_ram_wdata,
  input  wire logic        i_ram_we,
  output logic      [7:0]  o_rom_data,
  output logic      [3:0]  o_ram_rdata
);
  logic [7:0] rom_r [0:255]; // small image, upper address bits alias
  logic [3:0] ram_r [0:4095];
  // rom byte for the registered address, so it is seen at the next edge
  assign o_rom_data = rom_r[i_rom_addr[7:0]];
  // ram reads at once, writes on the strobe
  always_ff @(posedge i_clock) if (i_ram_we) ram_r[i_ram_addr] <= i_ram_wdata;
  assign o_ram_rdata = ram_r[i_ram_addr];
endmodule

//--- tb/testbench.sv
// self-checking bench for the stop, vector-entry and exchange block
// assumes bank selects stay zero so direct addresses land in bank 0
`timescale 1ns/100ps
module testbench;
  logic i_clock, i_nrst, i_wake, i_irq, i_interrupt_return_op, we, mbe, rbe, stp;
  logic [2:0] irq_num;
  logic [7:0] rd, acc;
  logic [3:0] rrd, wd, pcr;
  logic [13:0] ra, pc, ra_hold;
  logic [11:0] wa;
  int n_fail, n_compared;
  svxe_exec uut (.i_clock, .i_nrst, .i_rom_data(rd), .i_ram_rdata(rrd), .i_wake, .i_irq,
    .i_irq_num(irq_num), .i_interrupt_return_op, .i_reg_bank_sel(2'h0), .i_mem_bank(4'h0), .o_rom_addr(ra),
    .o_ram_addr(wa), .o_ram_wdata(wd), .o_ram_we(we), .o_pc(pc), .o_ext_acc(acc),
    .o_mem_bank_en(mbe), .o_reg_bank_en(rbe), .o_power_control_reg(pcr), .o_clock_stopped(stp));
  svxe_mem_model mem (.i_clock, .i_rom_addr(ra), .i_ram_addr(wa), .i_ram_wdata(wd),
    .i_ram_we(we), .o_rom_data(rd), .o_ram_rdata(rrd));
  initial begin
    i_clock = 0;
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic tick(int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reset entry through table slot zero
  task automatic t_reset_vector();
    for (int k = 0; k < 10 && pc !== 14'h0010; k++) tick(1);
    check("pc", pc, 16'h0010);
    check("flags", {mbe, rbe}, 16'h0002);
    $display("test reset_vector done");
  endtask
  // two exchanges back to back, then stop; both writes must have landed
  task automatic t_exchange_stop();
    for (int k = 0; k < 30 && stp !== 1'b1; k++) tick(1);
    check("ram20", mem.ram_r[12'h020], 16'h0000);
    check("ext_acc", acc, 16'h0097);
    check("ram30_31", {mem.ram_r[12'h031], mem.ram_r[12'h030]}, 16'h0005);
    check("pcon3", pcr[3], 16'h0001);
    ra_hold = ra;
    tick(5);
    check("halted_fetch", ra, ra_hold);
    $display("test exchange_stop done");
  endtask
  // wake, take interrupt one, then return restores the saved flags
  task automatic t_irq_return();
    i_wake = 1;
    for (int k = 0; k < 6 && stp !== 1'b0; k++) tick(1);
    i_wake = 0;
    tick(3);
    i_irq = 1;
    irq_num = 3'h1;
    tick(1);
    i_irq = 0;
    for (int k = 0; k < 10 && pc !== 14'h0040; k++) tick(1);
    check("irq_pc", pc, 16'h0040);
    check("irq_flags", {mbe, rbe}, 16'h0001);
    i_interrupt_return_op = 1;
    tick(1);
    i_interrupt_return_op = 0;
    tick(3);
    check("ret_flags", {mbe, rbe}, 16'h0002);
    $display("test irq_return done");
  endtask
  initial begin
    {i_nrst, i_wake, i_irq, i_interrupt_return_op, irq_num} = '0;
    foreach (mem.rom_r[i]) mem.rom_r[i] = 8'h00;
    foreach (mem.ram_r[i]) mem.ram_r[i] = 4'h0;
    {mem.rom_r[0], mem.rom_r[1], mem.rom_r[2], mem.rom_r[3]} = 32'h8010_4040;
    {mem.rom_r[16], mem.rom_r[17], mem.rom_r[18]} = 24'h7920CF;
    {mem.rom_r[19], mem.rom_r[20], mem.rom_r[21]} = 24'h30FFB3;
    {mem.ram_r[12'h020], mem.ram_r[12'h030], mem.ram_r[12'h031]} = 12'h579;
    tick(3);
    i_nrst = 1;
    t_reset_vector();
    t_exchange_stop();
    t_irq_return();
    end_of_test();
  end
  // hang guard, far beyond the few dozen cycles used
  initial begin
    #5000;
    n_fail++;
    end_of_test();
  end
endmodule
